// ===== inc/request_flag_map.svh
// register offsets, field layouts, reset values and bus codes of the request flag bank
`ifndef REQUEST_FLAG_MAP_SVH
`define REQUEST_FLAG_MAP_SVH

// byte offsets of the word-aligned registers
`define OFS_FLAGS_ONE 8'h00
`define OFS_FLAGS_TWO 8'h04
`define OFS_WAKE_FLAGS 8'h08
`define OFS_EDGE_SELECT 8'h0c
`define OFS_ENABLE_ONE 8'h10
`define OFS_ENABLE_TWO 8'h14
`define OFS_MASK_CTRL 8'h18

// writable bit masks and bits fixed at one
`define FLAGS_ONE_VALID 8'hdf
`define FLAGS_ONE_ONES 8'h20
`define FLAGS_TWO_VALID 8'hdc
`define FLAGS_TWO_ONES 8'h01
`define EDGE_SELECT_VALID 8'h1f

// reset values
`define FLAGS_ONE_RESET 8'h20
`define FLAGS_TWO_RESET 8'h01
`define WAKE_FLAGS_RESET 8'h00
`define EDGE_SELECT_RESET 5'h00
`define ENABLE_RESET 8'h00
`define GLOBAL_MASK_RESET 1'h1

// field positions
`define BIT_TIMER_A 7
`define BIT_SERIAL_ONE 6
`define BIT_WAKE_ENABLE 5
`define BIT_DIRECT 7
`define BIT_CONVERSION 6
`define BIT_TIMER_G 4
`define BIT_TIMER_FH 3
`define BIT_TIMER_FL 2

// counter limits used by overflow detection
`define COUNT_MAX 8'hff
`define COUNT_ZERO 8'h00

// bus response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== inc/request_flag_pkg.sv
// types of the request flag bank
package request_flag_pkg;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_DATA = 2'b10
	} rd_state_t;

	// timer f counters and compare registers
	typedef struct packed {
		logic [7:0] counter_f_low;
		logic [7:0] counter_f_high;
		logic [7:0] compare_f_low;
		logic [7:0] compare_f_high;
		logic wide_mode;
	} timer_f_t;

	// timer g counter and capture input
	typedef struct packed {
		logic [7:0] timer_g_counter;
		logic timer_g_capture_pin;
		logic capture_mode;
		logic capture_rising;
		logic overflow_irq_enable;
	} timer_g_t;

	typedef struct packed {
		logic [7:0] flags_one;
		logic [7:0] flags_two;
		logic [7:0] wake_flags;
		logic [4:0] edge_sel;
		logic [7:0] en_one;
		logic [7:0] en_two;
		logic gmask;
		logic primed;
		logic [4:0] ext_prev;
		logic [7:0] wake_prev;
		logic [7:0] ta_prev;
		logic [7:0] tg_prev;
		logic tg_pin_prev;
		logic fh_match_prev;
		logic fl_match_prev;
		wr_state_t wr;
		logic aw_got;
		logic w_got;
		logic [7:0] waddr;
		logic [7:0] wdata;
		logic wstrb0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		rd_state_t rd;
		logic arready;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic irq;
		logic [3:0] src;
	} state_t;

endpackage

// ===== design/interrupt_request_flag_bank.sv
// interrupt request flag bank with its register slave
`timescale 1ns/1ps
`include "request_flag_map.svh"
// ====================================================================
// Summary of operation
// - timer a wrap sets bit 7
// - flags clear only by writing zero
// - acceptance never clears a flag
// - serial one completion sets bit 6
// - first register bit 5 reads one
// - selected edge on ext pin n sets n
// - second register layout dt ad tg fh fl
// - direct transfer after sleep sets flag
// - conversion end with start clear sets flag
// - timer g capture or overflow sets flag
// - fh match in 8 or 16 bit
// - fl match in 8 bit mode
// - second register bits 5,1 read zero
// - second register bit 0 reads one
// - wakeup pin falling edge sets flag
// - edge select zero falling, one rising
// - enable and global mask gate request
// - highest priority request selected, ext0 first
module interrupt_request_flag_bank (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] timer_a_count,
	input wire logic serial_one_done,
	input wire logic [4:0] ext_irq_pin,
	input wire logic [4:0] ext_irq_mode,
	input wire logic direct_transfer_enable,
	input wire logic sleep_direct_transfer,
	input wire logic conversion_done,
	input wire logic conversion_start_flag,
	input wire request_flag_pkg::timer_g_t timer_g,
	input wire request_flag_pkg::timer_f_t timer_f,
	input wire logic [7:0] wakeup_pin,
	input wire logic [7:0] wakeup_pin_mode,
	output logic irq_out,
	output logic [3:0] irq_source
);

	request_flag_pkg::state_t s;
	request_flag_pkg::state_t n;
	logic [4:0] ext_set;
	logic [7:0] wake_set;
	logic ta_set;
	logic tg_set;
	logic dt_set;
	logic ad_set;
	logic fh_match;
	logic fl_match;
	logic [7:0] set_one;
	logic [7:0] set_two;
	logic [7:0] clr_one;
	logic [7:0] clr_two;
	logic [7:0] clr_wake;
	logic wr_do;
	logic wr_hit;
	logic [8:0] wr_word;
	logic [8:0] rd_word;
	logic [12:0] pend;

	// ====================================================================
	// register read decode
	function automatic logic [8:0] read_word(input logic [7:0] addr, input request_flag_pkg::state_t st);
		logic [8:0] r;
		r = {1'b1, 8'h00};
		case ({addr[7:2], 2'b00})
			`OFS_FLAGS_ONE: r = {1'b1, st.flags_one};
			`OFS_FLAGS_TWO: r = {1'b1, st.flags_two};
			`OFS_WAKE_FLAGS: r = {1'b1, st.wake_flags};
			`OFS_EDGE_SELECT: r = {1'b1, 3'h0, st.edge_sel};
			`OFS_ENABLE_ONE: r = {1'b1, st.en_one};
			`OFS_ENABLE_TWO: r = {1'b1, st.en_two};
			`OFS_MASK_CTRL: r = {1'b1, 7'h00, st.gmask};
			default: r = {1'b0, 8'h00};
		endcase
		return r;
	endfunction

	// lowest index wins: ext0..ext4, wakeup, then internal sources
	function automatic logic [3:0] pick(input logic [12:0] p);
		logic [3:0] k;
		k = 4'h0;
		for (int i = 12; i >= 0; i--) begin
			if (p[i]) begin
				k = 4'(i);
			end
		end
		return k;
	endfunction

	// ====================================================================
	// event detection; edges are ignored in the first cycle after reset
	always_comb begin
		ext_set = {5{s.primed}} & ext_irq_mode &
			((s.edge_sel & ext_irq_pin & ~s.ext_prev) | (~s.edge_sel & ~ext_irq_pin & s.ext_prev));
		wake_set = {8{s.primed}} & wakeup_pin_mode & ~wakeup_pin & s.wake_prev;
		ta_set = s.primed && s.ta_prev == `COUNT_MAX && timer_a_count == `COUNT_ZERO;
		tg_set = s.primed && ((timer_g.capture_mode && (timer_g.capture_rising ?
			(timer_g.timer_g_capture_pin && !s.tg_pin_prev) : (!timer_g.timer_g_capture_pin && s.tg_pin_prev)))
			|| (timer_g.overflow_irq_enable && s.tg_prev == `COUNT_MAX
			&& timer_g.timer_g_counter == `COUNT_ZERO));
		dt_set = direct_transfer_enable && sleep_direct_transfer;
		ad_set = conversion_done && !conversion_start_flag;
		// match is a level; only its rising edge sets so a clear can stick
		fh_match = timer_f.wide_mode ?
			({timer_f.counter_f_high, timer_f.counter_f_low} == {timer_f.compare_f_high, timer_f.compare_f_low}) :
			(timer_f.counter_f_high == timer_f.compare_f_high);
		fl_match = !timer_f.wide_mode && timer_f.counter_f_low == timer_f.compare_f_low;
		set_one = {ta_set, serial_one_done, 1'b0, ext_set};
		set_two = {dt_set, ad_set, 1'b0, tg_set, s.primed && fh_match && !s.fh_match_prev,
			s.primed && fl_match && !s.fl_match_prev, 2'b00};
	end

	// ====================================================================
	// next state: bus slave, flag update, request output
	always_comb begin
		n = s;
		wr_do = s.wr == request_flag_pkg::WR_IDLE && s.aw_got && s.w_got;
		// decoded once into words, since a bit-select of a call result is not portable
		wr_word = read_word(s.waddr, s);
		rd_word = read_word(s_axi_araddr, s);
		wr_hit = wr_word[8];
		clr_one = 8'h00;
		clr_two = 8'h00;
		clr_wake = 8'h00;
		// a zero written to a bit clears it; ones are ignored
		if (wr_do && s.wstrb0) begin
			case ({s.waddr[7:2], 2'b00})
				`OFS_FLAGS_ONE: clr_one = ~s.wdata;
				`OFS_FLAGS_TWO: clr_two = ~s.wdata;
				`OFS_WAKE_FLAGS: clr_wake = ~s.wdata;
				`OFS_EDGE_SELECT: n.edge_sel = s.wdata[4:0];
				`OFS_ENABLE_ONE: n.en_one = s.wdata;
				`OFS_ENABLE_TWO: n.en_two = (s.wdata & `FLAGS_TWO_VALID) | `FLAGS_TWO_ONES;
				`OFS_MASK_CTRL: n.gmask = s.wdata[0];
				default: n.gmask = s.gmask;
			endcase
		end
		// set is or-ed after the clear so a coincident event survives
		n.flags_one = (((s.flags_one & ~clr_one) | set_one) & `FLAGS_ONE_VALID) | `FLAGS_ONE_ONES;
		n.flags_two = (((s.flags_two & ~clr_two) | set_two) & `FLAGS_TWO_VALID) | `FLAGS_TWO_ONES;
		n.wake_flags = (s.wake_flags & ~clr_wake) | wake_set;
		// input history for edge and wrap detection
		n.primed = 1'b1;
		n.ext_prev = ext_irq_pin;
		n.wake_prev = wakeup_pin;
		n.ta_prev = timer_a_count;
		n.tg_prev = timer_g.timer_g_counter;
		n.tg_pin_prev = timer_g.timer_g_capture_pin;
		n.fh_match_prev = fh_match;
		n.fl_match_prev = fl_match;
		// write channel: address and data taken in either order
		if (s.awready && s_axi_awvalid) begin
			n.aw_got = 1'b1;
			n.waddr = s_axi_awaddr;
		end
		if (s.wready && s_axi_wvalid) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata[7:0];
			n.wstrb0 = s_axi_wstrb[0];
		end
		case (s.wr)
			request_flag_pkg::WR_IDLE: begin
				if (wr_do) begin
					n.wr = request_flag_pkg::WR_RESP;
					n.aw_got = 1'b0;
					n.w_got = 1'b0;
					n.bvalid = 1'b1;
					n.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
				end
			end
			request_flag_pkg::WR_RESP: begin
				if (s_axi_bready) begin
					n.wr = request_flag_pkg::WR_IDLE;
					n.bvalid = 1'b0;
				end
			end
			default: n.wr = request_flag_pkg::WR_IDLE;
		endcase
		n.awready = n.wr == request_flag_pkg::WR_IDLE && !n.aw_got;
		n.wready = n.wr == request_flag_pkg::WR_IDLE && !n.w_got;
		// read channel: data sampled at the address handshake
		case (s.rd)
			request_flag_pkg::RD_IDLE: begin
				if (s_axi_arvalid) begin
					n.rd = request_flag_pkg::RD_DATA;
					n.rvalid = 1'b1;
					n.rdata = rd_word[7:0];
					n.rresp = rd_word[8] ? `RESP_OKAY : `RESP_SLVERR;
				end
			end
			request_flag_pkg::RD_DATA: begin
				if (s_axi_rready) begin
					n.rd = request_flag_pkg::RD_IDLE;
					n.rvalid = 1'b0;
				end
			end
			default: n.rd = request_flag_pkg::RD_IDLE;
		endcase
		n.arready = n.rd == request_flag_pkg::RD_IDLE;
		// enabled requests; acceptance feeds nothing back here
		pend[4:0] = n.flags_one[4:0] & n.en_one[4:0];
		pend[5] = (|n.wake_flags) && n.en_one[`BIT_WAKE_ENABLE];
		pend[6] = n.flags_one[`BIT_TIMER_A] && n.en_one[`BIT_TIMER_A];
		pend[7] = n.flags_one[`BIT_SERIAL_ONE] && n.en_one[`BIT_SERIAL_ONE];
		pend[8] = n.flags_two[`BIT_DIRECT] && n.en_two[`BIT_DIRECT];
		pend[9] = n.flags_two[`BIT_CONVERSION] && n.en_two[`BIT_CONVERSION];
		pend[10] = n.flags_two[`BIT_TIMER_G] && n.en_two[`BIT_TIMER_G];
		pend[11] = n.flags_two[`BIT_TIMER_FH] && n.en_two[`BIT_TIMER_FH];
		pend[12] = n.flags_two[`BIT_TIMER_FL] && n.en_two[`BIT_TIMER_FL];
		n.irq = (|pend) && !n.gmask;
		n.src = pick(pend);
	end

	// ====================================================================
	// state register; clock enable freezes everything
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			s <= '0;
			s.flags_one <= `FLAGS_ONE_RESET;
			s.flags_two <= `FLAGS_TWO_RESET;
			s.wake_flags <= `WAKE_FLAGS_RESET;
			s.edge_sel <= `EDGE_SELECT_RESET;
			s.en_one <= `ENABLE_RESET;
			s.en_two <= `FLAGS_TWO_ONES;
			s.gmask <= `GLOBAL_MASK_RESET;
			s.wr <= request_flag_pkg::WR_IDLE;
			s.rd <= request_flag_pkg::RD_IDLE;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end else if (clk_en) begin
			s <= n;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rdata = {24'h000000, s.rdata};
	assign irq_out = s.irq;
	assign irq_source = s.src;

	// ====================================================================
	// checks
	AST_TIMER_A_WRAP: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && s.primed && s.ta_prev == 8'hff && timer_a_count == 8'h00 |=> s.flags_one[7])
		else $error("timer a wrap did not set its flag");
	AST_NO_SOFT_SET: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && !s.flags_one[6] && !serial_one_done |=> !s.flags_one[6])
		else $error("serial flag set without an event");
	AST_HOLD_UNTIL_CLEAR: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && s.flags_two[4] && !(wr_do && s.wstrb0 && s.waddr == 8'h04 && !s.wdata[4]) |=> s.flags_two[4])
		else $error("timer g flag fell without a clearing write");
	AST_FIXED_BITS: assert property (@(posedge core_clk) disable iff (!resetn)
		s.flags_one[5] && !s.flags_two[5] && !s.flags_two[1] && s.flags_two[0])
		else $error("fixed flag bits disturbed");
	AST_EXT_FALL: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && s.primed && ext_irq_mode[0] && !s.edge_sel[0] && s.ext_prev[0] && !ext_irq_pin[0]
		|=> s.flags_one[0])
		else $error("falling edge on ext 0 missed");
	AST_WAKE_FALL: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && s.primed && wakeup_pin_mode[7] && s.wake_prev[7] && !wakeup_pin[7] |=> s.wake_flags[7])
		else $error("wakeup falling edge missed");
	AST_CONV_END: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && conversion_done && !conversion_start_flag |=> s.flags_two[6])
		else $error("conversion end flag not set");
	AST_IRQ_GATE: assert property (@(posedge core_clk) disable iff (!resetn)
		irq_out == ((|(s.flags_one[4:0] & s.en_one[4:0]) || (s.flags_one[7] && s.en_one[7])
		|| (s.flags_one[6] && s.en_one[6]) || (|s.wake_flags && s.en_one[5])
		|| |(s.flags_two[7:2] & s.en_two[7:2])) && !s.gmask))
		else $error("request output not gated by enable and mask");
	AST_EXT0_FIRST: assert property (@(posedge core_clk) disable iff (!resetn)
		s.flags_one[0] && s.en_one[0] |-> irq_source == 4'h0)
		else $error("ext 0 not given top priority");
	AST_SET_WINS: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && serial_one_done && wr_do && s.wstrb0 && s.waddr == 8'h00 && !s.wdata[6] |=> s.flags_one[6])
		else $error("clear beat a coincident set");

	// ====================================================================
	// other sources, clock enable and read answer; quiet checks catch a flag that sets with no event
	AST_SERIAL_DONE: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && serial_one_done |=> s.flags_one[`BIT_SERIAL_ONE])
		else $error("serial completion did not set its flag");
	AST_DIRECT_SET: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && direct_transfer_enable && sleep_direct_transfer |=> s.flags_two[`BIT_DIRECT])
		else $error("direct transfer flag not set");
	AST_DIRECT_GATED: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && !direct_transfer_enable && !s.flags_two[`BIT_DIRECT] |=> !s.flags_two[`BIT_DIRECT])
		else $error("direct transfer flag set while disabled");
	AST_CONV_BUSY: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && conversion_start_flag && !s.flags_two[`BIT_CONVERSION] |=> !s.flags_two[`BIT_CONVERSION])
		else $error("conversion flag set while a conversion runs");
	AST_TIMER_G_WRAP: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && s.primed && timer_g.overflow_irq_enable && s.tg_prev == `COUNT_MAX
		&& timer_g.timer_g_counter == `COUNT_ZERO |=> s.flags_two[`BIT_TIMER_G])
		else $error("timer g wrap did not set its flag");
	AST_FH_WIDE_MATCH: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && s.primed && timer_f.wide_mode && !s.fh_match_prev
		&& {timer_f.counter_f_high, timer_f.counter_f_low} == {timer_f.compare_f_high, timer_f.compare_f_low}
		|=> s.flags_two[`BIT_TIMER_FH])
		else $error("sixteen bit match did not set the fh flag");
	AST_FL_WIDE_QUIET: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && timer_f.wide_mode && !s.flags_two[`BIT_TIMER_FL] |=> !s.flags_two[`BIT_TIMER_FL])
		else $error("fl flag set in sixteen bit mode");
	AST_EXT_RISE: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && s.primed && ext_irq_mode[0] && s.edge_sel[0] && !s.ext_prev[0] && ext_irq_pin[0]
		|=> s.flags_one[0])
		else $error("rising edge on ext 0 missed");
	AST_EXT_UNCONFIG: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && !ext_irq_mode[4] && !s.flags_one[4] |=> !s.flags_one[4])
		else $error("ext 4 flag set while not an interrupt input");
	AST_WAKE_UNCONFIG: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && !wakeup_pin_mode[6] && !s.wake_flags[6] |=> !s.wake_flags[6])
		else $error("wakeup 6 flag set while not a wakeup input");
	AST_MASK_HOLDS: assert property (@(posedge core_clk) disable iff (!resetn)
		s.gmask |-> !irq_out)
		else $error("request raised while globally masked");
	AST_FREEZE: assert property (@(posedge core_clk) disable iff (!resetn)
		!clk_en |=> $stable(s.flags_one) && $stable(s.flags_two) && $stable(s.wake_flags))
		else $error("flags moved while the clock enable was low");
	AST_READ_ANSWER: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read address taken without a data answer");

endmodule // interrupt_request_flag_bank

// ===== bench/timer_a_model.sv
// partner model: timer a counter feeding the request flag bank
`timescale 1ns/1ps
module timer_a_model (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic run,
	output logic [7:0] timer_a_count
);
	// ====================================================================
	// free counter; it wraps ff to 00 like the real timer, so the wrap needs 256 counts
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			timer_a_count <= 8'h00;
		end else if (run) begin
			timer_a_count <= timer_a_count + 8'h01;
		end
	end
endmodule // timer_a_model

// ===== bench/tb_top.sv
// self-checking bench of the request flag bank
`timescale 1ns/1ps
`include "request_flag_map.svh"
module tb_top;
	// ====================================================================
	// signals
	logic core_clk, resetn, clk_en, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, serial_done, dt_en, dt_sleep, conv_done, conv_start;
	logic irq_out, run_a;
	logic [7:0] awaddr, araddr, ta_count, wake_pin, wake_mode;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, irq_source;
	logic [1:0] bresp, rresp;
	logic [4:0] ext_pin, ext_mode;
	request_flag_pkg::timer_g_t tg;
	request_flag_pkg::timer_f_t tf;
	int num_errors, total_checks;

	interrupt_request_flag_bank interrupt_request_flag_bank_i (.core_clk(core_clk), .resetn(resetn),
		.clk_en(clk_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_a_count(ta_count),
		.serial_one_done(serial_done), .ext_irq_pin(ext_pin), .ext_irq_mode(ext_mode),
		.direct_transfer_enable(dt_en), .sleep_direct_transfer(dt_sleep), .conversion_done(conv_done),
		.conversion_start_flag(conv_start), .timer_g(tg), .timer_f(tf), .wakeup_pin(wake_pin),
		.wakeup_pin_mode(wake_mode), .irq_out(irq_out), .irq_source(irq_source));

	timer_a_model timer_a_model_i (.core_clk(core_clk), .resetn(resetn), .run(run_a), .timer_a_count(ta_count));

	// ====================================================================
	// clock, 5 ns period
	always #2.5 core_clk = ~core_clk;

	task automatic stop_test();
		if (num_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// ====================================================================
	// bus tasks; an idle edge first so ready/valid never get two assignments in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (n < 50) begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
			n++;
		end
		bready <= 1'b0;
		if (n == 50) begin
			num_errors++;
			stop_test();
		end
		chk("bresp", {30'h0, bresp}, {30'h0, r});
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (n < 50) begin
			@(posedge core_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
			n++;
		end
		rready <= 1'b0;
		if (n == 50) begin
			num_errors++;
			stop_test();
		end
		chk("rdata", rdata, {24'h000000, e});
		chk("rresp", {30'h0, rresp}, {30'h0, r});
	endtask

	// ====================================================================
	// main sequence
	initial begin
		core_clk = 0; resetn = 0; clk_en = 1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
		awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hf; serial_done = 0; dt_en = 0; dt_sleep = 0;
		conv_done = 0; conv_start = 1; run_a = 0; ext_pin = 5'h1f; ext_mode = 5'h0f; wake_pin = 8'hff;
		wake_mode = 8'hbf; tg = '0; tf = '0; tf.compare_f_low = 8'h05; tf.compare_f_high = 8'h05;
		num_errors = 0; total_checks = 0;
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		// reset values, fixed bits and a hole in the map
		rd(`OFS_FLAGS_ONE, 8'h20, `RESP_OKAY);
		rd(`OFS_FLAGS_TWO, 8'h01, `RESP_OKAY);
		rd(`OFS_MASK_CTRL, 8'h01, `RESP_OKAY);
		rd(8'h1c, 8'h00, `RESP_SLVERR);
		// software may not set flags, fixed bits ignore writes
		wr(`OFS_FLAGS_ONE, 8'hff, `RESP_OKAY);
		wr(`OFS_FLAGS_TWO, 8'h00, `RESP_OKAY);
		wr(`OFS_WAKE_FLAGS, 8'hff, `RESP_OKAY);
		rd(`OFS_FLAGS_ONE, 8'h20, `RESP_OKAY);
		rd(`OFS_FLAGS_TWO, 8'h01, `RESP_OKAY);
		rd(`OFS_WAKE_FLAGS, 8'h00, `RESP_OKAY);
		// serial completion, gated by enable then by global mask
		@(posedge core_clk) serial_done <= 1'b1;
		@(posedge core_clk) serial_done <= 1'b0;
		wr(`OFS_ENABLE_ONE, 8'h40, `RESP_OKAY);
		rd(`OFS_FLAGS_ONE, 8'h60, `RESP_OKAY);
		chk("irq_masked", {31'h0, irq_out}, 32'h0);
		wr(`OFS_MASK_CTRL, 8'h00, `RESP_OKAY);
		rd(`OFS_FLAGS_ONE, 8'h60, `RESP_OKAY);
		chk("irq_out", {31'h0, irq_out}, 32'h1);
		chk("irq_source", {28'h0, irq_source}, 32'h7);
		wr(`OFS_FLAGS_ONE, 8'hbf, `RESP_OKAY);
		rd(`OFS_FLAGS_ONE, 8'h20, `RESP_OKAY);
		chk("irq_clear", {31'h0, irq_out}, 32'h0);
		// timer a wrap after 256 counts
		run_a <= 1'b1;
		repeat (300) @(posedge core_clk);
		run_a <= 1'b0;
		rd(`OFS_FLAGS_ONE, 8'ha0, `RESP_OKAY);
		// ext pins: pin 2 falls, pin 0 rising-selected, pin 4 not configured
		wr(`OFS_EDGE_SELECT, 8'h01, `RESP_OKAY);
		@(posedge core_clk) ext_pin <= 5'h0a;
		@(posedge core_clk) ext_pin <= 5'h0b;
		rd(`OFS_FLAGS_ONE, 8'ha5, `RESP_OKAY);
		wr(`OFS_ENABLE_ONE, 8'h1f, `RESP_OKAY);
		rd(`OFS_FLAGS_ONE, 8'ha5, `RESP_OKAY);
		chk("ext_prio", {28'h0, irq_source}, 32'h0);
		wr(`OFS_FLAGS_ONE, 8'h00, `RESP_OKAY);
		// second register sources, start flag held high first
		@(posedge core_clk) conv_done <= 1'b1;
		@(posedge core_clk) conv_done <= 1'b0;
		rd(`OFS_FLAGS_TWO, 8'h01, `RESP_OKAY);
		conv_start <= 1'b0;
		dt_en <= 1'b1;
		tg.capture_mode <= 1'b1;
		tg.timer_g_capture_pin <= 1'b1;
		@(posedge core_clk) conv_done <= 1'b1;
		dt_sleep <= 1'b1;
		tg.timer_g_capture_pin <= 1'b0;
		tf.counter_f_low <= 8'h05;
		tf.counter_f_high <= 8'h05;
		@(posedge core_clk) conv_done <= 1'b0;
		dt_sleep <= 1'b0;
		rd(`OFS_FLAGS_TWO, 8'hdd, `RESP_OKAY);
		wr(`OFS_FLAGS_TWO, 8'h00, `RESP_OKAY);
		// sixteen-bit mode: low half match no longer flags
		tf.wide_mode <= 1'b1;
		tf.counter_f_low <= 8'h00;
		@(posedge core_clk) tf.counter_f_low <= 8'h05;
		rd(`OFS_FLAGS_TWO, 8'h09, `RESP_OKAY);
		// wakeup pins: pin 5 falls, pin 6 not configured
		@(posedge core_clk) wake_pin <= 8'h9f;
		rd(`OFS_WAKE_FLAGS, 8'h20, `RESP_OKAY);
		wr(`OFS_WAKE_FLAGS, 8'hdf, `RESP_OKAY);
		rd(`OFS_WAKE_FLAGS, 8'h00, `RESP_OKAY);
		// a clearing write landing with a serial completion keeps the flag; the write lands two edges after offer
		fork
			wr(`OFS_FLAGS_ONE, 8'hbf, `RESP_OKAY);
			begin
				repeat (2) @(posedge core_clk);
				serial_done <= 1'b1;
				@(posedge core_clk) serial_done <= 1'b0;
			end
		join
		rd(`OFS_FLAGS_ONE, 8'h60, `RESP_OKAY);
		wr(`OFS_FLAGS_ONE, 8'hbf, `RESP_OKAY);
		// clock enable low: an event in that cycle is not recorded
		@(posedge core_clk) clk_en <= 1'b0;
		serial_done <= 1'b1;
		@(posedge core_clk) serial_done <= 1'b0;
		clk_en <= 1'b1;
		rd(`OFS_FLAGS_ONE, 8'h20, `RESP_OKAY);
		// timer g wrap with its enable; a sleep transfer without its enable is ignored
		dt_en <= 1'b0;
		dt_sleep <= 1'b1;
		tg.overflow_irq_enable <= 1'b1;
		tg.timer_g_counter <= 8'hff;
		@(posedge core_clk) tg.timer_g_counter <= 8'h00;
		dt_sleep <= 1'b0;
		rd(`OFS_FLAGS_TWO, 8'h19, `RESP_OKAY);
		// second reset in mid-run brings the reset values back
		@(posedge core_clk) resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		chk("irq_reset", {31'h0, irq_out}, 32'h0);
		rd(`OFS_FLAGS_TWO, 8'h01, `RESP_OKAY);
		rd(`OFS_WAKE_FLAGS, 8'h00, `RESP_OKAY);
		rd(`OFS_MASK_CTRL, 8'h01, `RESP_OKAY);
		stop_test();
	end
endmodule // tb_top
